/* File: rtl/fap_sync.v */
// three-stage pin synchroniser exposing its second and third stages
`timescale 1ns/1ps
module fap_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] stage2,
  output wire [W-1:0] stage3
);

  reg [W-1:0] st1_reg;
  reg [W-1:0] st2_reg;
  reg [W-1:0] st3_reg;

  // pins idle high, so the chain resets to all ones
  always @(posedge clk) begin
    if (rst) begin
      st1_reg <= {W{1'b1}};
      st2_reg <= {W{1'b1}};
      st3_reg <= {W{1'b1}};
    end else begin
      st1_reg <= din;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  assign stage2 = st2_reg;
  assign stage3 = st3_reg;

endmodule // fap_sync

/* File: rtl/fap_top.v */
// request-phase strobe capture, parity generation and parity checking
`timescale 1ns/1ps
`include "fap_map.vh"

module fap_top #(
  parameter TX_PHASE = `FAP_TX_PHASE_CYC
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        address_valid_strobe_n_in,
  output wire        address_valid_strobe_n_out,
  output wire        address_valid_strobe_oe,
  input  wire [1:0]  addr_capture_strobe_pair_n_in,
  output wire [1:0]  addr_capture_strobe_pair_n_out,
  output wire        addr_capture_strobe_pair_oe,
  input  wire [35:3] addr_n_in,
  output wire [35:3] addr_n_out,
  output wire        addr_oe,
  input  wire [4:0]  req_n_in,
  output wire [4:0]  req_n_out,
  output wire        req_oe,
  input  wire [1:0]  request_parity_pair_n_in,
  output wire [1:0]  request_parity_pair_n_out,
  output wire        request_parity_pair_oe,
  input  wire        tx_start,
  input  wire [35:3] tx_addr,
  input  wire [35:3] tx_info,
  input  wire [4:0]  tx_req_a,
  input  wire [4:0]  tx_req_b,
  output wire        tx_ready,
  output wire        rx_valid,
  output wire [35:3] rx_addr,
  output wire [35:3] rx_info,
  output wire [4:0]  rx_req_a,
  output wire [4:0]  rx_req_b,
  output wire        rx_parity_err,
  output wire [3:0]  rx_err_bits
);

  // ----------------------------------------------------------------------
  // parity over active-low pin levels
  // ----------------------------------------------------------------------
  function fap_par;
    input [`FAP_PAR_W-1:0] v;
    input [`FAP_PAR_W-1:0] m;
    begin
      fap_par = ~(^(~v & m));
    end
  endfunction

  // pair index 0 and 1 for one subphase; sub=0 first, sub=1 second
  function [1:0] fap_pair;
    input [`FAP_PAR_W-1:0] v;
    input                  sub;
    reg                    top;
    reg                    rest;
    begin
      top  = fap_par(v, `FAP_MASK_TOP);
      rest = fap_par(v, `FAP_MASK_REST);
      fap_pair = sub ? {top, rest} : {rest, top};
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  wire [`FAP_SYNC_W-1:0] s2;
  wire [`FAP_SYNC_W-1:0] s3;

  fap_sync #(
    .W (`FAP_SYNC_W)
  ) u_sync (
    .clk    (ref_clk),
    .rst    (rst),
    .din    ({address_valid_strobe_n_in, addr_capture_strobe_pair_n_in,
              request_parity_pair_n_in, addr_n_in, req_n_in}),
    .stage2 (s2),
    .stage3 (s3)
  );

  // ----------------------------------------------------------------------
  // edge detection on agreed levels
  // ----------------------------------------------------------------------
  reg  stb0_q_reg;
  reg  stb1_q_reg;
  reg  valid_q_reg;

  wire stb0_chg  = (s2[`FAP_POS_STB0] == s3[`FAP_POS_STB0]) &&
                   (s3[`FAP_POS_STB0] != stb0_q_reg);
  wire stb1_chg  = (s2[`FAP_POS_STB1] == s3[`FAP_POS_STB1]) &&
                   (s3[`FAP_POS_STB1] != stb1_q_reg);
  wire valid_chg = (s2[`FAP_POS_VALID] == s3[`FAP_POS_VALID]) &&
                   (s3[`FAP_POS_VALID] != valid_q_reg);
  wire valid_go  = valid_chg && !s3[`FAP_POS_VALID];

  always @(posedge ref_clk) begin
    if (rst) begin
      stb0_q_reg  <= `FAP_PIN_IDLE;
      stb1_q_reg  <= `FAP_PIN_IDLE;
      valid_q_reg <= `FAP_PIN_IDLE;
    end else begin
      if (stb0_chg)
        stb0_q_reg <= s3[`FAP_POS_STB0];
      if (stb1_chg)
        stb1_q_reg <= s3[`FAP_POS_STB1];
      if (valid_chg)
        valid_q_reg <= s3[`FAP_POS_VALID];
    end
  end

  // ----------------------------------------------------------------------
  // receive capture
  // ----------------------------------------------------------------------
  reg        armed_reg;
  reg [3:0]  got_reg;
  reg [16:3] alo1_reg;
  reg [16:3] alo2_reg;
  reg [35:17] ahi1_reg;
  reg [35:17] ahi2_reg;
  reg [4:0]  req1_reg;
  reg [4:0]  req2_reg;
  reg [1:0]  par1_reg;
  reg [1:0]  par2_reg;
  reg        rx_valid_reg;
  reg        rx_err_reg;
  reg [3:0]  rx_bits_reg;
  reg [35:3] rx_addr_reg;
  reg [35:3] rx_info_reg;
  reg [4:0]  rx_req_a_reg;
  reg [4:0]  rx_req_b_reg;

  wire armed_now = armed_reg | valid_go;
  wire complete  = armed_reg && (got_reg == 4'hf) && !valid_go;
  wire [`FAP_PAR_W-1:0] v1 = {ahi1_reg, alo1_reg, req1_reg};
  wire [`FAP_PAR_W-1:0] v2 = {ahi2_reg, alo2_reg, req2_reg};
  wire [1:0] exp1 = fap_pair(v1, 1'b0);
  wire [1:0] exp2 = fap_pair(v2, 1'b1);
  wire [3:0] mism = {exp2 ^ par2_reg, exp1 ^ par1_reg};

  always @(posedge ref_clk) begin
    if (rst) begin
      armed_reg    <= 1'b0;
      got_reg      <= 4'h0;
      alo1_reg     <= {14{1'b1}};
      alo2_reg     <= {14{1'b1}};
      ahi1_reg     <= {19{1'b1}};
      ahi2_reg     <= {19{1'b1}};
      req1_reg     <= 5'h1f;
      req2_reg     <= 5'h1f;
      par1_reg     <= 2'h3;
      par2_reg     <= 2'h3;
      rx_valid_reg <= 1'b0;
      rx_err_reg   <= 1'b0;
      rx_bits_reg  <= 4'h0;
      rx_addr_reg  <= {33{1'b0}};
      rx_info_reg  <= {33{1'b0}};
      rx_req_a_reg <= 5'h00;
      rx_req_b_reg <= 5'h00;
    end else begin
      rx_valid_reg <= 1'b0;
      rx_err_reg   <= 1'b0;
      // a new valid strobe restarts the request, dropping any partial one
      if (valid_go) begin
        armed_reg <= 1'b1;
        got_reg   <= 4'h0;
      end
      if (armed_now && stb0_chg) begin
        if (!s3[`FAP_POS_STB0]) begin
          alo1_reg   <= s3[`FAP_POS_ALO_MSB:`FAP_POS_ALO_LSB];
          req1_reg   <= s3[`FAP_POS_REQ_MSB:`FAP_POS_REQ_LSB];
          got_reg[0] <= 1'b1;
        end else begin
          alo2_reg   <= s3[`FAP_POS_ALO_MSB:`FAP_POS_ALO_LSB];
          req2_reg   <= s3[`FAP_POS_REQ_MSB:`FAP_POS_REQ_LSB];
          got_reg[2] <= 1'b1;
        end
      end
      // parity is taken with the high group strobe edges
      if (armed_now && stb1_chg) begin
        if (!s3[`FAP_POS_STB1]) begin
          ahi1_reg   <= s3[`FAP_POS_AHI_MSB:`FAP_POS_AHI_LSB];
          par1_reg   <= s3[`FAP_POS_PAR_MSB:`FAP_POS_PAR_LSB];
          got_reg[1] <= 1'b1;
        end else begin
          ahi2_reg   <= s3[`FAP_POS_AHI_MSB:`FAP_POS_AHI_LSB];
          par2_reg   <= s3[`FAP_POS_PAR_MSB:`FAP_POS_PAR_LSB];
          got_reg[3] <= 1'b1;
        end
      end
      if (complete) begin
        armed_reg    <= 1'b0;
        got_reg      <= 4'h0;
        rx_valid_reg <= 1'b1;
        rx_addr_reg  <= ~{ahi1_reg, alo1_reg};
        rx_info_reg  <= ~{ahi2_reg, alo2_reg};
        rx_req_a_reg <= ~req1_reg;
        rx_req_b_reg <= ~req2_reg;
        rx_bits_reg  <= mism;
        rx_err_reg   <= |mism;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_SUB1 = 5'b00010;
  localparam ST_STBL = 5'b00100;
  localparam ST_SUB2 = 5'b01000;
  localparam ST_STBH = 5'b10000;

  reg [4:0]            state_reg;
  reg [`FAP_CNT_W-1:0] cnt_reg;
  reg [35:3]           tx_info_reg;
  reg [4:0]            tx_req_b_reg;
  reg                  valid_out_reg;
  reg [1:0]            stb_out_reg;
  reg [35:3]           a_out_reg;
  reg [4:0]            req_out_reg;
  reg [1:0]            par_out_reg;
  reg                  bus_oe_reg;

  wire [`FAP_CNT_W-1:0] phase_last = TX_PHASE[`FAP_CNT_W-1:0] - 1'b1;
  wire phase_end = (cnt_reg == phase_last);
  wire [`FAP_PAR_W-1:0] tv1 = ~{tx_addr, tx_req_a};
  wire [`FAP_PAR_W-1:0] tv2 = ~{tx_info_reg, tx_req_b_reg};

  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= {`FAP_CNT_W{1'b0}};
      tx_info_reg   <= {33{1'b0}};
      tx_req_b_reg  <= 5'h00;
      valid_out_reg <= `FAP_PIN_IDLE;
      stb_out_reg   <= 2'h3;
      a_out_reg     <= {33{1'b1}};
      req_out_reg   <= 5'h1f;
      par_out_reg   <= 2'h3;
      bus_oe_reg    <= 1'b0;
    end else begin
      cnt_reg <= phase_end ? {`FAP_CNT_W{1'b0}} : cnt_reg + 1'b1;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= {`FAP_CNT_W{1'b0}};
          if (tx_start) begin
            state_reg     <= ST_SUB1;
            tx_info_reg   <= tx_info;
            tx_req_b_reg  <= tx_req_b;
            a_out_reg     <= ~tx_addr;
            req_out_reg   <= ~tx_req_a;
            par_out_reg   <= fap_pair(tv1, 1'b0);
            valid_out_reg <= 1'b0;
            bus_oe_reg    <= 1'b1;
          end
        end
        ST_SUB1: begin
          if (phase_end) begin
            state_reg   <= ST_STBL;
            stb_out_reg <= 2'h0;
          end
        end
        ST_STBL: begin
          if (phase_end) begin
            state_reg     <= ST_SUB2;
            valid_out_reg <= `FAP_PIN_IDLE;
            a_out_reg     <= ~tx_info_reg;
            req_out_reg   <= ~tx_req_b_reg;
            par_out_reg   <= fap_pair(tv2, 1'b1);
          end
        end
        ST_SUB2: begin
          if (phase_end) begin
            state_reg   <= ST_STBH;
            stb_out_reg <= 2'h3;
          end
        end
        ST_STBH: begin
          if (phase_end) begin
            state_reg  <= ST_IDLE;
            bus_oe_reg <= 1'b0;
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          bus_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign tx_ready                       = (state_reg == ST_IDLE);
  assign address_valid_strobe_n_out     = valid_out_reg;
  assign address_valid_strobe_oe        = bus_oe_reg;
  assign addr_capture_strobe_pair_n_out = stb_out_reg;
  assign addr_capture_strobe_pair_oe    = bus_oe_reg;
  assign addr_n_out                     = a_out_reg;
  assign addr_oe                        = bus_oe_reg;
  assign req_n_out                      = req_out_reg;
  assign req_oe                         = bus_oe_reg;
  assign request_parity_pair_n_out      = par_out_reg;
  assign request_parity_pair_oe         = bus_oe_reg;
  assign rx_valid                       = rx_valid_reg;
  assign rx_addr                        = rx_addr_reg;
  assign rx_info                        = rx_info_reg;
  assign rx_req_a                       = rx_req_a_reg;
  assign rx_req_b                       = rx_req_b_reg;
  assign rx_parity_err                  = rx_err_reg;
  assign rx_err_bits                    = rx_bits_reg;

endmodule // fap_top

/* File: shared/fap_map.vh */
// constants for the request-phase capture and address parity block
`ifndef FAP_MAP_VH
`define FAP_MAP_VH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define FAP_ADDR_W        33
`define FAP_REQ_W         5
`define FAP_SYNC_W        43
`define FAP_PAR_W         38

// ----------------------------------------------------------------------
// positions inside the synchronised pin vector
// ----------------------------------------------------------------------
`define FAP_POS_REQ_LSB   0
`define FAP_POS_REQ_MSB   4
`define FAP_POS_ALO_LSB   5
`define FAP_POS_ALO_MSB   18
`define FAP_POS_AHI_LSB   19
`define FAP_POS_AHI_MSB   37
`define FAP_POS_PAR_LSB   38
`define FAP_POS_PAR_MSB   39
`define FAP_POS_STB0      40
`define FAP_POS_STB1      41
`define FAP_POS_VALID     42

// ----------------------------------------------------------------------
// parity coverage masks over {addr[35:3], req[4:0]}
// ----------------------------------------------------------------------
`define FAP_MASK_TOP      38'h3f_fc00_0000
`define FAP_MASK_REST     38'h00_03ff_ffff

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define FAP_PIN_IDLE      1'b1
`define FAP_CLK_NS        4
`define FAP_TX_PHASE_NS   32
`define FAP_TX_PHASE_CYC  ((`FAP_TX_PHASE_NS + `FAP_CLK_NS - 1) / `FAP_CLK_NS)
`define FAP_CNT_W         8

`endif

/* File: tb/fap_agent.sv */
// far-side bus agent issuing request phases on the pins
`timescale 1ns/1ps
module fap_agent (
  output logic        valid_n,
  output logic [1:0]  stb_n,
  output logic [35:3] a_n,
  output logic [4:0]  r_n,
  output logic [1:0]  p_n
);
  // idle is high: lines are terminated to the high level
  initial begin
    valid_n = 1'b1;
    stb_n = 2'b11;
    a_n = '1;
    r_n = 5'h1f;
    p_n = 2'b11;
  end
  // mask bits {s2 p1, s2 p0, s1 p1, s1 p0} flip the sent parity
  task automatic send(input logic [35:3] ad, input logic [35:3] inf,
                      input logic [4:0] ra, input logic [4:0] rb,
                      input logic [3:0] bad);
    valid_n = 1'b0;
    a_n = ~ad;
    r_n = ~ra;
    p_n = {~^{ad[23:3], ra}, ~^ad[35:24]} ^ bad[1:0];
    #62.5 stb_n = 2'b00;
    #62.5 valid_n = 1'b1;
    a_n = ~inf;
    r_n = ~rb;
    p_n = {~^inf[35:24], ~^{inf[23:3], rb}} ^ bad[3:2];
    #62.5 stb_n = 2'b11;
    #62.5 a_n = '1;
    r_n = 5'h1f;
    p_n = 2'b11;
  endtask
endmodule // fap_agent

/* File: tb/fap_checker.sv */
// port-level assertions for the request-phase parity block
`timescale 1ns/1ps
module fap_checker #(
  parameter int TX_PHASE = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        tx_start,
  input wire logic        tx_ready,
  input wire logic [35:3] tx_addr,
  input wire logic [35:3] tx_info,
  input wire logic [4:0]  tx_req_a,
  input wire logic [4:0]  tx_req_b,
  input wire logic        address_valid_strobe_n_out,
  input wire logic        addr_oe,
  input wire logic [35:3] addr_n_out,
  input wire logic [4:0]  req_n_out,
  input wire logic [1:0]  request_parity_pair_n_out,
  input wire logic [1:0]  addr_capture_strobe_pair_n_out,
  input wire logic        rx_valid,
  input wire logic        rx_parity_err,
  input wire logic [3:0]  rx_err_bits
);
  localparam int STB = TX_PHASE + 1;
  localparam int SUB2 = 2 * TX_PHASE + 1;
  localparam int DONE = 4 * TX_PHASE + 1;
  logic go;
  assign go = tx_start & tx_ready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_tx_launch: assert property (go |=> !address_valid_strobe_n_out && addr_oe
    && addr_n_out == ~$past(tx_addr) && req_n_out == ~$past(tx_req_a))
    else $error("launch pins wrong");
  a_tx_par_sub1: assert property (go |=> request_parity_pair_n_out ==
    {~^{$past(tx_addr[23:3]), $past(tx_req_a)}, ~^$past(tx_addr[35:24])})
    else $error("subphase one parity wrong");
  a_tx_sub2_pins: assert property (go |-> ##SUB2 addr_n_out ==
    ~$past(tx_info, SUB2) && req_n_out == ~$past(tx_req_b, SUB2))
    else $error("subphase two pins wrong");
  a_tx_par_sub2: assert property (go |-> ##SUB2 request_parity_pair_n_out ==
    {~^$past(tx_info[35:24], SUB2),
     ~^{$past(tx_info[23:3], SUB2), $past(tx_req_b, SUB2)}})
    else $error("subphase two parity wrong");
  a_strobe_low: assert property (go |-> ##STB
    addr_capture_strobe_pair_n_out == 2'b00)
    else $error("strobes not asserted");
  a_tx_busy: assert property (go |=> !tx_ready [*8])
    else $error("ready during transfer");
  a_tx_done: assert property (go |-> ##DONE tx_ready && !addr_oe)
    else $error("transfer did not end");
  a_err_hold: assert property (!rx_valid |-> $stable(rx_err_bits))
    else $error("error bits changed");
  a_err_sum: assert property (rx_valid |->
    rx_parity_err == (rx_err_bits != 4'h0))
    else $error("error flag disagrees");
  a_err_pulse: assert property (rx_parity_err |-> rx_valid)
    else $error("error without valid");
  c_tx: cover property (go ##DONE tx_ready);
  c_rx: cover property (rx_valid && !rx_parity_err);
  c_err: cover property (rx_parity_err);
endmodule // fap_checker

/* File: tb/fap_top_tb_top.sv */
// self-checking bench for the request-phase parity block
`timescale 1ns/1ps
module fap_top_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_start = 1'b0;
  logic [35:3] tx_addr = '0, tx_info = '0;
  logic [4:0] tx_req_a = 5'h00, tx_req_b = 5'h00;
  wire v_o, v_oe, s_oe, a_oe, r_oe, p_oe, tx_ready, rx_valid, rx_parity_err;
  wire [1:0] s_o, p_o, g_s, g_p;
  wire [35:3] a_o, g_a, rx_addr, rx_info;
  wire [4:0] r_o, g_r, rx_req_a, rx_req_b;
  wire [3:0] rx_err_bits;
  wire g_v;
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  fap_agent agent (.valid_n(g_v), .stb_n(g_s), .a_n(g_a), .r_n(g_r),
                   .p_n(g_p));
  fap_top #(.TX_PHASE(8)) dut (.ref_clk(ref_clk), .rst(rst),
    .address_valid_strobe_n_in(v_oe ? v_o : g_v),
    .address_valid_strobe_n_out(v_o), .address_valid_strobe_oe(v_oe),
    .addr_capture_strobe_pair_n_in(s_oe ? s_o : g_s),
    .addr_capture_strobe_pair_n_out(s_o), .addr_capture_strobe_pair_oe(s_oe),
    .addr_n_in(a_oe ? a_o : g_a), .addr_n_out(a_o), .addr_oe(a_oe),
    .req_n_in(r_oe ? r_o : g_r), .req_n_out(r_o), .req_oe(r_oe),
    .request_parity_pair_n_in(p_oe ? p_o : g_p),
    .request_parity_pair_n_out(p_o), .request_parity_pair_oe(p_oe),
    .tx_start(tx_start), .tx_addr(tx_addr), .tx_info(tx_info),
    .tx_req_a(tx_req_a), .tx_req_b(tx_req_b), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_info(rx_info),
    .rx_req_a(rx_req_a), .rx_req_b(rx_req_b),
    .rx_parity_err(rx_parity_err), .rx_err_bits(rx_err_bits));
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // waits for the received-request pulse, sampled after the edge settles
  task automatic wait_rx();
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      #1;
      if (rx_valid === 1'b1) return;
    end
    n_mismatch++;
    close_out();
  endtask
  task automatic t_reset();
    chk({tx_ready, rx_valid, rx_parity_err, a_oe, v_oe, s_oe}, 6'h20);
    chk({rx_err_bits, s_o, v_o}, 7'h07);
  endtask
  // own request looped back through the pins
  task automatic t_tx(input logic [35:3] ad, input logic [35:3] inf,
                      input logic [4:0] ra, input logic [4:0] rb);
    @(posedge ref_clk);
    tx_start <= 1'b1;
    tx_addr <= ad;
    tx_info <= inf;
    tx_req_a <= ra;
    tx_req_b <= rb;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    wait_rx();
    chk(rx_addr, ad);
    chk(rx_info, inf);
    chk({rx_req_a, rx_req_b}, {ra, rb});
    chk({rx_parity_err, rx_err_bits}, 5'h00);
    for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(tx_ready, 1'b1);
  endtask
  // request from the far agent, parity flipped per mask
  task automatic t_rx(input logic [35:3] ad, input logic [35:3] inf,
                      input logic [4:0] ra, input logic [4:0] rb,
                      input logic [3:0] bad);
    fork
      agent.send(ad, inf, ra, rb, bad);
      begin
        // the error flag stands for one cycle only, beside the valid pulse
        wait_rx();
        chk(rx_parity_err, |bad);
      end
    join
    chk({rx_addr, rx_req_a}, {ad, ra});
    chk({rx_info, rx_req_b}, {inf, rb});
    chk(rx_err_bits, bad);
    repeat (20) @(posedge ref_clk);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 t_reset();
    t_tx(33'h1_ffff_ffff, 33'h0_0000_0000, 5'h1f, 5'h00);
    t_tx(33'h1_2345_6789, 33'h0_abcd_ef01, 5'h0a, 5'h15);
    t_rx(33'h0_f0f0_f0f0, 33'h1_0f0f_0f0f, 5'h11, 5'h0e, 4'h0);
    for (int k = 0; k < 4; k++)
      t_rx(33'h1_8000_0001 << k, 33'h0_7fff_fffe, 5'h03, 5'h1c,
           4'h1 << k);
    t_rx(33'h0_0000_0000, 33'h1_ffff_ffff, 5'h00, 5'h1f, 4'hf);
    close_out();
  end
endmodule // fap_top_tb_top
bind fap_top fap_checker #(.TX_PHASE(TX_PHASE)) u_chk (.*);
